// File: logic/dsfs_sequencer.v
`timescale 1ns/10ps
`include "dsfs_map.vh"

// ==========================================================
// Byte FIFO
module dsfs_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire             ce,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      level;
  wire            do_wr;
  wire            do_rd;
  integer         i;

  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = ce & in_valid & in_ready;
  assign do_rd     = ce & out_valid & out_ready;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                      : wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                 : rd_ptr + 1'b1;
      if (do_wr & ~do_rd)
        level <= level + 1'b1;
      else if (do_rd & ~do_wr)
        level <= level - 1'b1;
    end
  end
endmodule // dsfs_fifo

// ==========================================================
// Sector format sequencer
module dsfs_sequencer (
  // Clock, reset, enable
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        ce,
  // Avalon-MM register slave
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Drive timing pulses
  input  wire        index_pulse,
  input  wire        sector_pulse,
  // Byte stream to drive
  output reg  [7:0]  out_data,
  output reg  [4:0]  out_field,
  output reg         out_valid,
  input  wire        out_ready,
  // Status
  output reg         busy
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_ARM   = 2'b01;
  localparam ST_FIELD = 2'b10;
  localparam ST_FILL  = 2'b11;

  reg  [7:0]  rf [0:`DSFS_LAST_RW];
  reg  [1:0]  state;
  reg  [4:0]  fld;
  reg  [16:0] cnt;
  reg  [7:0]  sect_no;
  reg         mode_fmt;
  reg         mode_hard;
  reg         idx_d;
  reg         sec_d;
  reg  [31:0] next_readdata;
  reg  [7:0]  cur_pat;
  wire [6:0]  idx;
  wire        idx_ok;
  wire        take;
  wire        index_ev;
  wire        sector_ev;
  wire        last_sect;
  wire        gap_fill;
  wire        push;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [12:0] fifo_out_data;
  wire        pop;
  wire [4:0]  fld_next;
  integer     i;

  assign idx       = avs_address[8:2];
  assign idx_ok    = ((idx >= `DSFS_HDR_PAT0) && (idx <= `DSFS_HDR_PAT5))
                   || ((idx >= `DSFS_DATA_TAIL_N) && (idx <= `DSFS_STATUS));
  assign take      = ~avs_waitrequest & (avs_read | avs_write);
  assign index_ev  = index_pulse & ~idx_d;
  assign sector_ev = sector_pulse & ~sec_d;
  assign last_sect = (sect_no + 8'h01 >= rf[`DSFS_SECTS]);
  assign fld_next  = fld + 5'h01;

  // ========================================================
  // Field length and pattern lookup
  function [16:0] field_len;
    input [4:0] f;
    begin
      case (f)
        5'h00: field_len = {12'h000, rf[`DSFS_ID_LEAD_N][4:0]};
        5'h01: field_len = {12'h000, rf[`DSFS_ID_MARK_N][4:0]};
        5'h02: field_len = {12'h000, rf[`DSFS_ID_SYNC2_N][4:0]};
        5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08:
          field_len = (rf[`DSFS_HDR_CTL0 + {2'b00, f - `DSFS_F_HDR0}]
                       != `DSFS_ZERO_BYTE) ? `DSFS_ONE_CNT
                                           : `DSFS_ZERO_CNT;
        5'h09, 5'h10:
          field_len = {14'h0000, rf[`DSFS_DISK_FMT][2:0]};
        5'h0A: field_len = {12'h000, rf[`DSFS_ID_EXT_N][4:0]};
        5'h0B: field_len = {12'h000, rf[`DSFS_ID_TAIL_N][4:0]};
        5'h0C: field_len = {12'h000, rf[`DSFS_DATA_LEAD_N][4:0]};
        5'h0D: field_len = {12'h000, rf[`DSFS_DATA_MARK_N][4:0]};
        5'h0E: field_len = {12'h000, rf[`DSFS_DATA_SYNC2_N][4:0]};
        5'h0F:
          field_len = ({rf[`DSFS_SECT_LEN_HI], rf[`DSFS_SECT_LEN_LO]}
                       == 16'h0000) ? `DSFS_FULL_SECTOR
                       : {1'b0, rf[`DSFS_SECT_LEN_HI],
                          rf[`DSFS_SECT_LEN_LO]};
        5'h11: field_len = {12'h000, rf[`DSFS_DATA_EXT_N][4:0]};
        5'h12: field_len = {12'h000, rf[`DSFS_DATA_TAIL_N][4:0]};
        5'h13: field_len = {9'h000, rf[`DSFS_GAP_N]};
        default: field_len = `DSFS_ZERO_CNT;
      endcase
    end
  endfunction

  always @*
  begin
    case (fld)
      5'h00: cur_pat = rf[`DSFS_ID_LEAD_P];
      5'h01: cur_pat = rf[`DSFS_ID_MARK_P];
      5'h02: cur_pat = rf[`DSFS_ID_SYNC2_P];
      5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08:
        cur_pat = rf[`DSFS_HDR_PAT0 + {2'b00, fld - `DSFS_F_HDR0}];
      5'h0B: cur_pat = rf[`DSFS_ID_TAIL_P];
      5'h0C: cur_pat = rf[`DSFS_DATA_LEAD_P];
      5'h0D: cur_pat = rf[`DSFS_DATA_MARK_P];
      5'h0E: cur_pat = rf[`DSFS_DATA_SYNC2_P];
      5'h0F: cur_pat = rf[`DSFS_DATA_FILL_P];
      5'h12: cur_pat = rf[`DSFS_DATA_TAIL_P];
      5'h13: cur_pat = rf[`DSFS_GAP_P];
      // Check and external bytes go out as zero, tagged by field
      default: cur_pat = `DSFS_ZERO_BYTE;
    endcase
  end

  // Gap is counted or runs to a pulse
  assign gap_fill = mode_hard ? (~mode_fmt | last_sect)
                              : last_sect;
  assign push = ((state == ST_FIELD) && (cnt != `DSFS_ZERO_CNT))
              || (state == ST_FILL);

  // ========================================================
  // Register read data
  always @*
  begin
    next_readdata = 32'h00000000;
    if (idx_ok)
    begin
      if (idx == `DSFS_STATUS)
        next_readdata = {16'h0000, sect_no, 2'b00, fld[4:0], busy};
      else
        next_readdata = {24'h000000, rf[idx]};
    end
  end

  // ========================================================
  // Bus slave and register file
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      for (i = 0; i <= `DSFS_LAST_RW; i = i + 1)
        rf[i] <= `DSFS_ZERO_BYTE;
    end
    else if (ce)
    begin
      // One wait cycle: read data is latched before release
      if (avs_waitrequest & (avs_read | avs_write))
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= next_readdata;
      end
      else
        avs_waitrequest <= 1'b1;
      // Start is a self-clearing strobe; a write in the same cycle wins
      if (rf[`DSFS_CTRL][`DSFS_CTRL_START] & (state == ST_IDLE))
        rf[`DSFS_CTRL][`DSFS_CTRL_START] <= 1'b0;
      if (take & avs_write & idx_ok & (idx != `DSFS_STATUS))
        rf[idx] <= avs_writedata[7:0];
    end
  end

  // ========================================================
  // Sector sequencer
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state     <= ST_IDLE;
      fld       <= `DSFS_F_ID_LEAD;
      cnt       <= `DSFS_ZERO_CNT;
      sect_no   <= 8'h00;
      mode_fmt  <= 1'b0;
      mode_hard <= 1'b0;
      idx_d     <= 1'b0;
      sec_d     <= 1'b0;
      busy      <= 1'b0;
    end
    else if (ce)
    begin
      idx_d <= index_pulse;
      sec_d <= sector_pulse;
      case (state)
        ST_IDLE:
        begin
          busy <= 1'b0;
          if (rf[`DSFS_CTRL][`DSFS_CTRL_START])
          begin
            mode_fmt  <= rf[`DSFS_CTRL][`DSFS_CTRL_FORMAT];
            mode_hard <= rf[`DSFS_CTRL][`DSFS_CTRL_HARD];
            busy      <= 1'b1;
            state     <= ST_ARM;
          end
        end
        ST_ARM:
        begin
          // Track opens on index; hard writes open on sector mark
          if ((mode_fmt | ~mode_hard) ? index_ev : sector_ev)
          begin
            sect_no <= 8'h00;
            fld     <= `DSFS_F_ID_LEAD;
            cnt     <= field_len(`DSFS_F_ID_LEAD);
            state   <= ST_FIELD;
          end
        end
        ST_FIELD:
        begin
          if (mode_fmt & index_ev)
            state <= ST_IDLE;
          else if (cnt == `DSFS_ZERO_CNT)
          begin
            if (fld == `DSFS_F_GAP)
            begin
              if (mode_fmt)
              begin
                sect_no <= sect_no + 8'h01;
                fld     <= `DSFS_F_ID_LEAD;
                cnt     <= field_len(`DSFS_F_ID_LEAD);
              end
              else
                state <= ST_IDLE;
            end
            else
            begin
              fld <= fld_next;
              // Lookup at the edge sees all register writes up to the previous cycle
              if ((fld_next == `DSFS_F_GAP) & gap_fill)
                state <= ST_FILL;
              else
                cnt <= field_len(fld_next);
            end
          end
          else if (fifo_in_ready)
            cnt <= cnt - `DSFS_ONE_CNT;
        end
        ST_FILL:
        begin
          if (mode_fmt ? index_ev : (mode_hard ? sector_ev : index_ev))
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ========================================================
  // Output buffer; drive side back-pressure stalls the fields
  dsfs_fifo #(
    .WIDTH (`DSFS_WORD_W),
    .DEPTH (`DSFS_FIFO_DEPTH),
    .AW    (`DSFS_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({fld, cur_pat}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // Output stage refills whenever it is empty or its byte is taken
  assign pop = ~out_valid | out_ready;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_data  <= `DSFS_ZERO_BYTE;
      out_field <= 5'h00;
    end
    else if (ce & pop)
    begin
      out_valid <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        out_data  <= fifo_out_data[7:0];
        out_field <= fifo_out_data[12:8];
      end
    end
  end
endmodule // dsfs_sequencer

// File: logic/dsfs_map.vh
`ifndef DSFS_MAP_VH
`define DSFS_MAP_VH
// ==========================================================
// Register indexes (byte address is four times the index)
`define DSFS_HDR_PAT0     7'h14
`define DSFS_HDR_PAT5     7'h19
`define DSFS_DATA_TAIL_N  7'h20
`define DSFS_ID_LEAD_N    7'h21
`define DSFS_ID_MARK_N    7'h22
`define DSFS_ID_SYNC2_N   7'h23
`define DSFS_HDR_CTL0     7'h24
`define DSFS_DATA_EXT_N   7'h2A
`define DSFS_ID_EXT_N     7'h2B
`define DSFS_ID_TAIL_N    7'h2C
`define DSFS_DATA_LEAD_N  7'h2D
`define DSFS_DATA_MARK_N  7'h2E
`define DSFS_DATA_SYNC2_N 7'h2F
`define DSFS_DATA_TAIL_P  7'h30
`define DSFS_ID_LEAD_P    7'h31
`define DSFS_ID_MARK_P    7'h32
`define DSFS_ID_SYNC2_P   7'h33
`define DSFS_GAP_N        7'h34
`define DSFS_DISK_FMT     7'h35
`define DSFS_SECT_LEN_LO  7'h38
`define DSFS_SECT_LEN_HI  7'h39
`define DSFS_GAP_P        7'h3A
`define DSFS_DATA_FILL_P  7'h3B
`define DSFS_ID_TAIL_P    7'h3C
`define DSFS_DATA_LEAD_P  7'h3D
`define DSFS_DATA_MARK_P  7'h3E
`define DSFS_DATA_SYNC2_P 7'h3F
`define DSFS_CTRL         7'h40
`define DSFS_SECTS        7'h41
`define DSFS_STATUS       7'h42
`define DSFS_LAST_RW      7'h41
// ==========================================================
// Control bits
`define DSFS_CTRL_START   0
`define DSFS_CTRL_FORMAT  1
`define DSFS_CTRL_HARD    2
// ==========================================================
// Field numbers in emission order
`define DSFS_F_ID_LEAD    5'h00
`define DSFS_F_HDR0       5'h03
`define DSFS_F_HDR5       5'h08
`define DSFS_F_ID_CHK     5'h09
`define DSFS_F_ID_EXT     5'h0A
`define DSFS_F_ID_TAIL    5'h0B
`define DSFS_F_DATA_LEAD  5'h0C
`define DSFS_F_DATA_MARK  5'h0D
`define DSFS_F_DATA_SYNC2 5'h0E
`define DSFS_F_DATA       5'h0F
`define DSFS_F_DATA_CHK   5'h10
`define DSFS_F_DATA_EXT   5'h11
`define DSFS_F_DATA_TAIL  5'h12
`define DSFS_F_GAP        5'h13
// ==========================================================
// Sizes and constants
`define DSFS_FIFO_DEPTH   8
`define DSFS_FIFO_AW      3
`define DSFS_WORD_W       13
`define DSFS_ZERO_BYTE    8'h00
`define DSFS_ZERO_CNT     17'h00000
`define DSFS_FULL_SECTOR  17'h10000
`define DSFS_ONE_CNT      17'h00001
`endif

// File: dv/dsfs_props.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the sector sequencer
module dsfs_props (
  // Clock and reset
  input logic        sys_clk,
  input logic        reset_n,
  input logic        ce,
  // Register bus
  input logic [8:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  // Drive side
  input logic        index_pulse,
  input logic        sector_pulse,
  input logic [7:0]  out_data,
  input logic [4:0]  out_field,
  input logic        out_valid,
  input logic        out_ready,
  input logic        busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire        take = out_valid && out_ready;
  logic [4:0] last_f;
  logic [5:0] run_n;
  logic       armed;
  // Run length restarts at 1 after 63 so an open-ended gap never wraps to 0
  always @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      last_f <= 5'h00;
      run_n  <= 6'h00;
      armed  <= 1'h0;
    end
    else
    begin
      if (take)
        last_f <= out_field;
      if (take)
        run_n <= (out_field == last_f && run_n != 6'h3F) ? run_n + 6'h01
                 : 6'h01;
      armed <= $rose(busy) || (armed && !index_pulse && !sector_pulse);
    end
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_stream_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_field)) else $error("stalled byte changed");
  a_field_order: assert property (
    take |-> out_field <= 5'h13 && (out_field >= last_f || out_field == 5'h00))
    else $error("field out of order");
  a_check_zero: assert property (
    out_valid && (out_field == 5'h09 || out_field == 5'h0A
    || out_field == 5'h10 || out_field == 5'h11) |-> out_data == 8'h00)
    else $error("check byte not zero");
  a_tail_limit: assert property (
    last_f != 5'h0F && last_f != 5'h13 |-> run_n <= 6'h1F)
    else $error("field longer than 31 bytes");
  a_hdr_single: assert property (
    last_f >= 5'h03 && last_f <= 5'h08 |-> run_n <= 6'h01)
    else $error("header byte repeated");
  a_wait_start: assert property (armed |-> !out_valid)
    else $error("bytes before start pulse");
  c_stall: cover property (out_valid && !out_ready ##1 out_valid);
  c_gap: cover property (take && out_field == 5'h13);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // dsfs_props

// File: dv/dsfs_drive_model.sv
`timescale 1ns/10ps
// ==========================================================
// Drive model: takes bytes, makes index and sector pulses
module dsfs_drive_model (
  // Clock and reset
  input  logic       sys_clk,
  input  logic       reset_n,
  // Stream from sequencer
  input  logic [7:0] out_data,
  input  logic [4:0] out_field,
  input  logic       out_valid,
  output logic       out_ready,
  // Timing pulses
  output logic       index_pulse,
  output logic       sector_pulse,
  // Bench control: stall holds ready low
  input  logic       stall
);
  logic [12:0] got_q[$];
  initial
  begin
    index_pulse = 1'h0;
    sector_pulse = 1'h0;
  end
  always @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      out_ready <= 1'h0;
    else
      out_ready <= !stall;
  always @(posedge sys_clk)
    if (reset_n && out_valid && out_ready)
      got_q.push_back({out_field, out_data});
  // Pulse lasts two cycles so the rise is surely seen
  task pulse(input logic sel);
    @(posedge sys_clk);
    if (sel)
      sector_pulse <= 1'h1;
    else
      index_pulse <= 1'h1;
    repeat (2) @(posedge sys_clk);
    index_pulse <= 1'h0;
    sector_pulse <= 1'h0;
  endtask
endmodule // dsfs_drive_model

// File: dv/tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// Bench top
module tb_top;
  logic        sys_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [8:0]  avs_address = 9'h000;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        index_pulse;
  logic        sector_pulse;
  logic [7:0]  out_data;
  logic [4:0]  out_field;
  logic        out_valid;
  logic        out_ready;
  logic        busy;
  logic        stall = 1'h0;
  logic [31:0] rd;
  logic [12:0] exp_q[$];
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;
  // Counts 0x20-0x2F; no two omitted fields in a row
  localparam logic [7:0] cnt_tab [16] = '{8'h02, 8'h01, 8'h01, 8'h00,
    8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00,
    8'h01, 8'h00};
  // One sector as {field, byte, repeat}, counted gap last
  localparam logic [23:0] sec_tab [14] = '{24'h00B101, 24'h01B201,
    24'h039401, 24'h059601, 24'h079801, 24'h090001, 24'h0A0002, 24'h0BBC03,
    24'h0DBE01, 24'h0FBB04, 24'h100001, 24'h110001, 24'h12B002, 24'h13BA03};
  always #5 sys_clk = ~sys_clk;
  dsfs_sequencer dsfs_sequencer_i (
    .sys_clk, .reset_n, .ce(1'h1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .index_pulse,
    .sector_pulse, .out_data, .out_field, .out_valid, .out_ready, .busy);
  dsfs_drive_model dsfs_drive_model_i (
    .sys_clk, .reset_n, .out_data, .out_field, .out_valid, .out_ready,
    .index_pulse, .sector_pulse, .stall);
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One edge first, so a strobe is never set twice in a time step
  task bus(input logic wr, input logic [6:0] idx, input logic [7:0] val);
    @(posedge sys_clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, val};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  // Last sector has no counted gap: it runs until the end pulse
  task run_op(input logic [7:0] ctrl, input logic sel, input int secs,
              input int extra);
    exp_q.delete();
    dsfs_drive_model_i.got_q.delete();
    for (n = 0; n < secs * 14 - 1; n++)
      repeat (sec_tab[n % 14][7:0])
        exp_q.push_back(sec_tab[n % 14][20:8]);
    stall <= 1'h1;
    bus(1'h1, 7'h40, ctrl);
    while (busy !== 1'h1)
      @(posedge sys_clk);
    dsfs_drive_model_i.pulse(sel);
    repeat (40) @(posedge sys_clk);
    check(dsfs_drive_model_i.got_q.size(), 0);
    check(out_valid, 1'h1);
    stall <= 1'h0;
    while (dsfs_drive_model_i.got_q.size() < exp_q.size() + extra)
      @(posedge sys_clk);
    dsfs_drive_model_i.pulse(sel);
    while (busy !== 1'h0)
      @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    check(out_valid, 1'h0);
    for (n = 0; n < exp_q.size(); n++)
      check(dsfs_drive_model_i.got_q[n], exp_q[n]);
    for (; n < dsfs_drive_model_i.got_q.size(); n++)
      check(dsfs_drive_model_i.got_q[n], {5'h13, 8'hBA});
    check(dsfs_drive_model_i.got_q.size() > exp_q.size() + 3, 1'h1);
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'h1;
    bus(1'h0, 7'h2C, 8'h00);
    check(rd, 32'h0);
    for (n = 0; n < 16; n++)
      bus(1'h1, 7'h20 + n[6:0], cnt_tab[n]);
    for (n = 0; n < 16; n++)
      bus(1'h1, 7'h30 + n[6:0], 8'hB0 + n[7:0]);
    for (n = 0; n < 6; n++)
      bus(1'h1, 7'h14 + n[6:0], 8'h94 + n[7:0]);
    bus(1'h1, 7'h34, 8'h03);
    bus(1'h1, 7'h35, 8'h01);
    bus(1'h1, 7'h38, 8'h04);
    bus(1'h1, 7'h39, 8'h00);
    bus(1'h1, 7'h41, 8'h02);
    for (n = 2; n < 14; n++)
      bus(1'h1, n[6:0], 8'h00);
    bus(1'h1, 7'h7F, 8'h5A);
    bus(1'h0, 7'h7F, 8'h00);
    check(rd, 32'h0);
    bus(1'h0, 7'h3C, 8'h00);
    check(rd, 32'hBC);
    run_op(8'h03, 1'h0, 2, 8);
    bus(1'h0, 7'h42, 8'h00);
    check(rd, 32'h126);
    run_op(8'h07, 1'h0, 2, 8);
    run_op(8'h05, 1'h1, 1, 6);
    close_out();
  end
endmodule // tb_top
bind dsfs_sequencer dsfs_props dsfs_props_i (
  .sys_clk, .reset_n, .ce, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .index_pulse,
  .sector_pulse, .out_data, .out_field, .out_valid, .out_ready, .busy);
